/* dbg_mem_policy.sv */
// Purpose: Debug memory access policy engine between APB and a target debug port
// Assumes: Target answers with a four-phase req/ack handshake; link clock is sampled
// Notes:   Request changes only on sampled rising edges of the link clock
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ns

// What this block does
// [R1] Each debug memory write waits the configured microseconds, 0 to 10000000, reset zero.
// [R2] Parity disabled by default; operations then carry no computed parity.
// [R3] With parity enabled, only data-line parity is generated, never address parity.
// [R4] Default treats the target data bus as 64 bits wide.
// [R5] Narrow bus mode caps every access at 4 bytes, even when 8 requested.
// [R6] Host must set bus width to match the target's reset-latched width.
// [R7] Data-retry setting is ignored while both caches are disabled.
// [R8] Data-retry option, off by default; host matches target powerup pin.
// [R9] Both caches disabled or physical read option gives physical memory contents.
// [R10] Coherent read returns cache contents on a hit, else physical memory.
// [R11] Valid instruction cache contents are decoded; invalid ones stay raw.
// [R12] Download writes physical memory and invalidates cache entries for the address.
// [R13] A write without a space given is an instruction memory write.
// [R14] Data cache disabled sends data writes straight to physical memory.
// [R15] Coherent policy: hit writes cache only, marks dirty; miss writes memory.
// [R16] Write-through: hit writes cache and memory; miss writes memory only.
// [R17] Bypass policy writes physical memory only, data cache untouched.
// [R18] Write delay counted with a one-microsecond tick from the system clock.
module dbg_mem_policy (
  // Clock and reset
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_SYS_RST,
  // APB slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic                      PREADY,
  output logic [31:0]               PRDATA,
  output logic                      PSLVERR,
  // Target debug port
  input  wire logic                 I_LINK_CLK,
  input  wire logic                 I_ICACHE_ENABLE_BIT,
  input  wire logic                 I_DCACHE_ENABLE_BIT,
  input  wire dbg_mem_pkg::tgt_ans_t I_TGT_ANS,
  output dbg_mem_pkg::tgt_op_t      O_TGT_OP
);

  typedef enum logic [2:0] {ST_IDLE, ST_LK_REQ, ST_LK_REL, ST_DELAY, ST_WR_REQ, ST_WR_REL}
    state_t;

  // Registers
  logic [31:0]              ctrl_r;
  logic [23:0]              wr_delay_r;
  logic [31:0]              addr_r;
  logic [63:0]              wdata_r;
  logic [63:0]              rdata_r;
  dbg_mem_pkg::cmd_kind_t   kind_r;
  dbg_mem_pkg::cmd_space_t  space_r;
  logic                     size8_r;
  logic                     done_r;
  state_t                   state_r;
  logic [23:0]              us_left_r;
  logic [6:0]               tick_cnt_r;
  logic                     hit_i_r;
  logic                     hit_d_r;

  // Synchronisers
  logic                     link_s1_r, link_s2_r, link_s3_r;
  logic [1:0]               ce_s1_r, ce_s2_r;
  dbg_mem_pkg::tgt_ans_t    ans_s1_r, ans_s2_r;

  logic                     link_rise;
  logic                     caches_off;
  logic                     apb_wr;
  logic                     cmd_go;
  logic                     us_tick;
  dbg_mem_pkg::wr_policy_t  wpol;
  logic [31:0]              rd_mux;
  logic                     rd_ok;
  logic [23:0]              wd_in;

  // Even parity per data byte
  function automatic logic [7:0] byte_parity(input logic [63:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      link_s1_r <= 1'b0;
      link_s2_r <= 1'b0;
      link_s3_r <= 1'b0;
      ce_s1_r   <= 2'b00;
      ce_s2_r   <= 2'b00;
      ans_s1_r  <= '0;
      ans_s2_r  <= '0;
    end else begin
      link_s1_r <= I_LINK_CLK;
      link_s2_r <= link_s1_r;
      link_s3_r <= link_s2_r;
      ce_s1_r   <= {I_ICACHE_ENABLE_BIT, I_DCACHE_ENABLE_BIT};
      ce_s2_r   <= ce_s1_r;
      ans_s1_r  <= I_TGT_ANS;
      ans_s2_r  <= ans_s1_r;
    end
  end

  assign link_rise  = link_s2_r & ~link_s3_r;
  assign caches_off = ~ce_s2_r[1] & ~ce_s2_r[0];
  assign wpol       = dbg_mem_pkg::wr_policy_t'(ctrl_r[dbg_mem_pkg::CTRL_WRPOL_LSB +: 2]);
  assign apb_wr     = PSEL & PENABLE & PREADY & PWRITE;
  assign cmd_go     = apb_wr & (PADDR == dbg_mem_pkg::OFS_CMD) & (state_r == ST_IDLE);
  assign wd_in      = (PWDATA > 32'(dbg_mem_pkg::WR_DELAY_MAX)) ? dbg_mem_pkg::WR_DELAY_MAX
                                                               : PWDATA[23:0];

  // Read decode, also used to flag unmapped addresses
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (PADDR)
      dbg_mem_pkg::OFS_CTRL:     rd_mux = ctrl_r;
      dbg_mem_pkg::OFS_WR_DELAY: rd_mux = {8'h00, wr_delay_r};
      dbg_mem_pkg::OFS_ADDR:     rd_mux = addr_r;
      dbg_mem_pkg::OFS_WDATA_LO: rd_mux = wdata_r[31:0];
      dbg_mem_pkg::OFS_WDATA_HI: rd_mux = wdata_r[63:32];
      dbg_mem_pkg::OFS_CMD:      rd_mux = {27'h000_0000, size8_r, space_r, kind_r};
      dbg_mem_pkg::OFS_STATUS: begin
        rd_mux[dbg_mem_pkg::STAT_BUSY_BIT] = (state_r != ST_IDLE);
        rd_mux[dbg_mem_pkg::STAT_DONE_BIT] = done_r;
        rd_mux[dbg_mem_pkg::STAT_ICACHE_EN_BIT] = ce_s2_r[1];
        rd_mux[dbg_mem_pkg::STAT_DCACHE_EN_BIT] = ce_s2_r[0];
      end
      dbg_mem_pkg::OFS_RDATA_LO: rd_mux = rdata_r[31:0];
      dbg_mem_pkg::OFS_RDATA_HI: rd_mux = rdata_r[63:32];
      default:                   rd_ok  = 1'b0;
    endcase
  end

  // APB answer: one wait state, registered outputs
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL & PENABLE & ~PREADY) begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
      PSLVERR <= ~rd_ok | (PWRITE & (PADDR == dbg_mem_pkg::OFS_CMD) & (state_r != ST_IDLE))
                 | (PWRITE & (PADDR == dbg_mem_pkg::OFS_STATUS));
    end else begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      ctrl_r     <= dbg_mem_pkg::CTRL_RESET; // R2 R4 R8
      wr_delay_r <= dbg_mem_pkg::WR_DELAY_RESET; // R1
      addr_r     <= 32'h0000_0000;
      wdata_r    <= 64'h0000_0000_0000_0000;
    end else if (apb_wr) begin
      case (PADDR)
        dbg_mem_pkg::OFS_CTRL:     ctrl_r <= {26'h000_0000, PWDATA[5:0]};
        dbg_mem_pkg::OFS_WR_DELAY: wr_delay_r <= wd_in; // R1
        dbg_mem_pkg::OFS_ADDR:     addr_r <= PWDATA;
        dbg_mem_pkg::OFS_WDATA_LO: wdata_r[31:0] <= PWDATA;
        dbg_mem_pkg::OFS_WDATA_HI: wdata_r[63:32] <= PWDATA;
        default: ;
      endcase
    end
  end

  // Command capture and completion flag
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      kind_r  <= dbg_mem_pkg::KIND_READ;
      space_r <= dbg_mem_pkg::SPACE_ANY;
      size8_r <= 1'b0;
      done_r  <= 1'b0;
    end else if (cmd_go) begin
      kind_r  <= dbg_mem_pkg::cmd_kind_t'(PWDATA[dbg_mem_pkg::CMD_KIND_LSB +: 2]);
      space_r <= dbg_mem_pkg::cmd_space_t'(PWDATA[dbg_mem_pkg::CMD_SPACE_LSB +: 2]);
      size8_r <= PWDATA[dbg_mem_pkg::CMD_SIZE8_BIT];
      done_r  <= 1'b0;
    end else if ((state_r == ST_LK_REL && kind_r == dbg_mem_pkg::KIND_READ
                  || state_r == ST_WR_REL) && link_rise && ~ans_s2_r.ack) begin
      done_r  <= 1'b1;
    end
  end

  // One microsecond tick, restarted on entry to the delay
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST || state_r != ST_DELAY) begin
      tick_cnt_r <= 7'h00;
    end else if (us_tick) begin
      tick_cnt_r <= 7'h00; // R18
    end else begin
      tick_cnt_r <= tick_cnt_r + 7'h01; // R18
    end
  end
  assign us_tick = (tick_cnt_r == 7'(dbg_mem_pkg::TICK_CYCLES - 1));

  // Sequencer
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      state_r   <= ST_IDLE;
      us_left_r <= 24'h00_0000;
    end else begin
      case (state_r)
        ST_IDLE: if (cmd_go) begin
          state_r <= ST_LK_REQ;
        end
        ST_LK_REQ: if (ans_s2_r.ack && O_TGT_OP.req && link_rise) begin
          state_r <= ST_LK_REL;
        end
        ST_LK_REL: if (link_rise && ~ans_s2_r.ack) begin
          if (kind_r == dbg_mem_pkg::KIND_READ) begin
            state_r <= ST_IDLE;
          end else begin
            state_r   <= ST_DELAY;
            us_left_r <= wr_delay_r; // R1
          end
        end
        ST_DELAY: if (us_left_r == 24'h00_0000) begin
          state_r <= ST_WR_REQ; // R1
        end else if (us_tick) begin
          us_left_r <= us_left_r - 24'h00_0001; // R18
        end
        ST_WR_REQ: if (ans_s2_r.ack && O_TGT_OP.req && link_rise) begin
          state_r <= ST_WR_REL;
        end
        ST_WR_REL: if (link_rise && ~ans_s2_r.ack) begin
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Lookup result: hits and read data selection
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      hit_i_r <= 1'b0;
      hit_d_r <= 1'b0;
      rdata_r <= 64'h0000_0000_0000_0000;
    end else if (state_r == ST_LK_REQ && ans_s2_r.ack && O_TGT_OP.req && link_rise) begin
      hit_i_r <= ans_s2_r.icache_hit & ce_s2_r[1];
      hit_d_r <= ans_s2_r.dcache_hit & ce_s2_r[0];
      if (caches_off || ctrl_r[dbg_mem_pkg::CTRL_RDPHYS_BIT]) begin
        rdata_r <= ans_s2_r.phys_data; // R9
      end else if (ans_s2_r.dcache_hit && ce_s2_r[0]) begin
        rdata_r <= ans_s2_r.dcache_data; // R10
      end else if (ans_s2_r.icache_hit && ce_s2_r[1]) begin
        rdata_r <= ans_s2_r.instr_valid ? (ans_s2_r.icache_data ^ dbg_mem_pkg::ICODE_KEY)
                                        : ans_s2_r.icache_data; // R11
      end else begin
        rdata_r <= ans_s2_r.phys_data; // R10
      end
      if (ctrl_r[dbg_mem_pkg::CTRL_NARROW_BIT] || !size8_r) begin
        rdata_r[63:32] <= 32'h0000_0000; // R5
      end
    end
  end

  // Operation to the target, changed only on link clock rising edges
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_TGT_OP <= '0;
    end else if (link_rise) begin
      case (state_r)
        ST_LK_REQ, ST_WR_REQ: begin
          O_TGT_OP.req         <= ~ans_s2_r.ack;
          O_TGT_OP.write_phase <= (state_r == ST_WR_REQ);
          O_TGT_OP.addr        <= addr_r;
          O_TGT_OP.size4       <= ctrl_r[dbg_mem_pkg::CTRL_NARROW_BIT] | ~size8_r; // R4 R5
          O_TGT_OP.retry_mode  <= ctrl_r[dbg_mem_pkg::CTRL_RETRY_BIT] & ~caches_off; // R7 R8
          if (ctrl_r[dbg_mem_pkg::CTRL_NARROW_BIT] || !size8_r) begin
            O_TGT_OP.data <= {32'h0000_0000, wdata_r[31:0]}; // R5
          end else begin
            O_TGT_OP.data <= wdata_r; // R4
          end
          if (ctrl_r[dbg_mem_pkg::CTRL_PARITY_BIT] && state_r == ST_WR_REQ) begin
            O_TGT_OP.data_parity <= byte_parity(
              (ctrl_r[dbg_mem_pkg::CTRL_NARROW_BIT] || !size8_r)
                ? {32'h0000_0000, wdata_r[31:0]} : wdata_r); // R3
          end else begin
            O_TGT_OP.data_parity <= 8'h00; // R2
          end
          O_TGT_OP.wr_phys    <= 1'b0;
          O_TGT_OP.wr_icache  <= 1'b0;
          O_TGT_OP.wr_dcache  <= 1'b0;
          O_TGT_OP.mark_dirty <= 1'b0;
          O_TGT_OP.inv_icache <= 1'b0;
          O_TGT_OP.inv_dcache <= 1'b0;
          if (state_r == ST_WR_REQ) begin
            if (kind_r == dbg_mem_pkg::KIND_DOWNLOAD) begin
              O_TGT_OP.wr_phys    <= 1'b1; // R12
              O_TGT_OP.inv_icache <= hit_i_r; // R12
              O_TGT_OP.inv_dcache <= hit_d_r; // R12
            end else if (space_r != dbg_mem_pkg::SPACE_DATA) begin
              O_TGT_OP.wr_phys   <= 1'b1; // R13
              O_TGT_OP.wr_icache <= hit_i_r;
              O_TGT_OP.wr_dcache <= hit_d_r;
            end else if (!ce_s2_r[0] || !hit_d_r) begin
              O_TGT_OP.wr_phys <= 1'b1; // R14 R15 R16
            end else begin
              case (wpol)
                dbg_mem_pkg::WPOL_THRU: begin
                  O_TGT_OP.wr_phys   <= 1'b1; // R16
                  O_TGT_OP.wr_dcache <= 1'b1; // R16
                end
                dbg_mem_pkg::WPOL_BYPASS: O_TGT_OP.wr_phys <= 1'b1; // R17
                default: begin
                  O_TGT_OP.wr_dcache  <= 1'b1; // R15
                  O_TGT_OP.mark_dirty <= 1'b1; // R15
                end
              endcase
            end
          end
        end
        default: O_TGT_OP.req <= 1'b0;
      endcase
    end
  end

endmodule // dbg_mem_policy

/* dbg_mem_pkg.sv */
// Purpose: Shared constants and carriers for the debug memory access policy block
// Assumes: 100 MHz system clock, APB register access with 32-bit data
// Notes:   Register offsets are byte addresses
package dbg_mem_pkg;

  // Clock and timing
  localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
  localparam int unsigned US_PER_S      = 1_000_000;
  localparam int unsigned TICK_CYCLES   = CLK_FREQ_HZ / US_PER_S;
  localparam int unsigned WR_DELAY_MAX_US = 10_000_000;
  localparam logic [23:0] WR_DELAY_MAX  = 24'(WR_DELAY_MAX_US);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_WR_DELAY = 8'h04;
  localparam logic [7:0] OFS_ADDR     = 8'h08;
  localparam logic [7:0] OFS_WDATA_LO = 8'h0C;
  localparam logic [7:0] OFS_WDATA_HI = 8'h10;
  localparam logic [7:0] OFS_CMD      = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_RDATA_LO = 8'h1C;
  localparam logic [7:0] OFS_RDATA_HI = 8'h20;

  // Control register fields
  localparam int CTRL_PARITY_BIT = 0;
  localparam int CTRL_NARROW_BIT = 1;
  localparam int CTRL_RETRY_BIT  = 2;
  localparam int CTRL_RDPHYS_BIT = 3;
  localparam int CTRL_WRPOL_LSB  = 4;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [23:0] WR_DELAY_RESET = 24'h00_0000;

  // Command register fields
  localparam int CMD_KIND_LSB  = 0;
  localparam int CMD_SPACE_LSB = 2;
  localparam int CMD_SIZE8_BIT = 4;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ICACHE_EN_BIT = 2;
  localparam int STAT_DCACHE_EN_BIT = 3;

  // Arbitrary key used to decode instruction cache contents
  localparam logic [63:0] ICODE_KEY = 64'hA5A5_5A5A_A5A5_5A5A;

  typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_DOWNLOAD, KIND_RSVD} cmd_kind_t;
  typedef enum logic [1:0] {SPACE_ANY, SPACE_INSTR, SPACE_DATA, SPACE_RSVD} cmd_space_t;
  typedef enum logic [1:0] {WPOL_COHERENT, WPOL_THRU, WPOL_BYPASS, WPOL_RSVD} wr_policy_t;

  // Answer from the target debug port
  typedef struct packed {
    logic        ack;
    logic        icache_hit;
    logic        dcache_hit;
    logic        instr_valid;
    logic [63:0] phys_data;
    logic [63:0] icache_data;
    logic [63:0] dcache_data;
  } tgt_ans_t;

  // Operation presented to the target debug port
  typedef struct packed {
    logic        req;
    logic        write_phase;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0]  data_parity;
    logic        size4;
    logic        retry_mode;
    logic        wr_phys;
    logic        wr_icache;
    logic        wr_dcache;
    logic        mark_dirty;
    logic        inv_icache;
    logic        inv_dcache;
  } tgt_op_t;

endpackage

/* dbg_mem_policy_props.sv */
// Purpose: Port-level temporal checks for the debug memory policy block
// Assumes: Cache enables change only while no target operation runs
// Notes:   Bound onto every instance of the block
`timescale 1ns/1ns
module dbg_mem_policy_props (
  // Clock and reset
  input wire logic                  I_SYS_CLK,
  input wire logic                  I_SYS_RST,
  // APB
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [7:0]            PADDR,
  input wire logic [31:0]           PWDATA,
  input wire logic                  PREADY,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PSLVERR,
  // Target port
  input wire logic                  I_LINK_CLK,
  input wire logic                  I_ICACHE_ENABLE_BIT,
  input wire logic                  I_DCACHE_ENABLE_BIT,
  input wire dbg_mem_pkg::tgt_ans_t I_TGT_ANS,
  input wire dbg_mem_pkg::tgt_op_t  O_TGT_OP
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  property p_ready_wait;
    $rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("access phase length wrong");
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_qual;
    PSLVERR |-> PREADY && PSEL && PENABLE;
  endproperty
  a_err_qual: assert property (p_err_qual) else $error("error outside an access");
  property p_rdata_idle;
    !PREADY |-> PRDATA == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  property p_lookup_par;
    O_TGT_OP.req && !O_TGT_OP.write_phase |-> O_TGT_OP.data_parity == 8'h00;
  endproperty
  a_lookup_par: assert property (p_lookup_par) else $error("parity on lookup");
  property p_size4_hi;
    O_TGT_OP.req && O_TGT_OP.size4 |-> O_TGT_OP.data[63:32] == 32'h0000_0000;
  endproperty
  a_size4_hi: assert property (p_size4_hi) else $error("upper data on narrow access");
  property p_dirty;
    O_TGT_OP.req && O_TGT_OP.mark_dirty |-> O_TGT_OP.wr_dcache && !O_TGT_OP.wr_phys;
  endproperty
  a_dirty: assert property (p_dirty) else $error("dirty mark without cache only write");
  property p_dl_inv;
    O_TGT_OP.req && (O_TGT_OP.inv_icache || O_TGT_OP.inv_dcache)
      |-> O_TGT_OP.wr_phys && !O_TGT_OP.wr_icache && !O_TGT_OP.wr_dcache;
  endproperty
  a_dl_inv: assert property (p_dl_inv) else $error("invalidate with cache write");
  property p_nodc;
    O_TGT_OP.req && O_TGT_OP.wr_dcache |-> I_DCACHE_ENABLE_BIT;
  endproperty
  a_nodc: assert property (p_nodc) else $error("data cache written while disabled");
  property p_retry_off;
    O_TGT_OP.req && !I_ICACHE_ENABLE_BIT && !I_DCACHE_ENABLE_BIT |-> !O_TGT_OP.retry_mode;
  endproperty
  a_retry_off: assert property (p_retry_off) else $error("retry with caches off");
endmodule // dbg_mem_policy_props

bind dbg_mem_policy dbg_mem_policy_props chk_u (
  .I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
  .PSLVERR(PSLVERR), .I_LINK_CLK(I_LINK_CLK), .I_ICACHE_ENABLE_BIT(I_ICACHE_ENABLE_BIT),
  .I_DCACHE_ENABLE_BIT(I_DCACHE_ENABLE_BIT), .I_TGT_ANS(I_TGT_ANS), .O_TGT_OP(O_TGT_OP));

/* tgt_model.sv */
// Purpose: Behavioural target debug port with four-phase ack
// Assumes: Link clock runs only while the bench asks for a frame
// Notes:   Released data lines show the inverse of their answer
`timescale 1ns/1ns
module tgt_model #(
  parameter logic [63:0] PHYS = 64'h0000_0000_0000_0000,
  parameter logic [63:0] ICV  = 64'h0000_0000_0000_0000,
  parameter logic [63:0] DCV  = 64'h0000_0000_0000_0000
) (
  // Controls from the bench
  input  wire logic                 i_run,
  input  wire logic                 i_slow,
  input  wire logic                 i_ihit,
  input  wire logic                 i_dhit,
  input  wire logic                 i_ivalid,
  // Link
  input  wire dbg_mem_pkg::tgt_op_t i_op,
  output logic                      o_lclk,
  output dbg_mem_pkg::tgt_ans_t     o_ans,
  // Observations
  output dbg_mem_pkg::tgt_op_t      o_last_wr,
  output int                        o_gap_ns
);
  logic ack;
  int   wait_n;
  time  t_req;

  initial begin
    o_lclk    = 1'b0;
    ack       = 1'b0;
    wait_n    = 0;
    t_req     = 0;
    o_gap_ns  = 0;
    o_last_wr = '0;
    forever begin
      wait (i_run);
      #62 o_lclk = 1'b1;
      #63 o_lclk = 1'b0;
    end
  end

  // Ack on falling link edge, optionally after a few extra cycles
  always @(negedge o_lclk) begin
    if (!i_op.req) begin
      ack    <= 1'b0;
      wait_n <= i_slow ? 3 : 0;
    end else if (!ack && wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (!ack) begin
      ack <= 1'b1;
      if (i_op.write_phase) begin
        o_last_wr <= i_op;
      end
    end
  end

  always @(posedge i_op.req) begin
    o_gap_ns = int'($time - t_req);
    t_req    = $time;
  end

  assign o_ans = {ack, i_ihit, i_dhit, i_ivalid, ack ? PHYS : ~PHYS,
                  ack ? ICV : ~ICV, ack ? DCV : ~DCV};
endmodule // tgt_model

/* dbg_mem_policy_test.sv */
// Purpose: Self-checking bench for the debug memory policy block
// Assumes: APB master tasks, behavioural target model
// Notes:   Write delay kept at zero except the last two writes (2 us check, busy check), to keep the run short
`timescale 1ns/1ns
module dbg_mem_policy_test;
  localparam logic [63:0] PHYS = 64'h1111_2222_3333_4444;
  localparam logic [63:0] ICV  = 64'h5555_6666_7777_8888;
  localparam logic [63:0] DCV  = 64'h9999_aaaa_bbbb_cccc;
  logic                  I_SYS_CLK, I_SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic                  I_ICACHE_ENABLE_BIT, I_DCACHE_ENABLE_BIT, lclk;
  logic                  run, slow, ihit, dhit, ivalid, err;
  logic [7:0]            PADDR;
  logic [31:0]           PWDATA, PRDATA, q;
  dbg_mem_pkg::tgt_ans_t ans;
  dbg_mem_pkg::tgt_op_t  op, last_wr;
  int                    gap, n_fail, comparisons, i;
  logic [8:0]            rc [7];
  logic [63:0]           rx [7];
  logic [14:0]           wc [7];
  logic [14:0]           wx [7];

  dbg_mem_policy dut_u (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PRDATA(PRDATA), .PSLVERR(PSLVERR), .I_LINK_CLK(lclk),
    .I_ICACHE_ENABLE_BIT(I_ICACHE_ENABLE_BIT), .I_DCACHE_ENABLE_BIT(I_DCACHE_ENABLE_BIT),
    .I_TGT_ANS(ans), .O_TGT_OP(op));
  tgt_model #(.PHYS(PHYS), .ICV(ICV), .DCV(DCV)) tgt_u (.i_run(run), .i_slow(slow),
    .i_ihit(ihit), .i_dhit(dhit), .i_ivalid(ivalid), .i_op(op), .o_lclk(lclk), .o_ans(ans),
    .o_last_wr(last_wr), .o_gap_ns(gap));

  initial begin
    I_SYS_CLK = 1'b0;
    forever #5 I_SYS_CLK = ~I_SYS_CLK;
  end

  task conclude;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge I_SYS_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge I_SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    q   = PRDATA;
    err = PSLVERR;
    if (n >= 50) begin
      n_fail++;
      conclude;
    end
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge I_SYS_CLK);
  endtask

  task run_op(input logic [31:0] c, input logic [31:0] m);
    int n;
    apb(1'b1, dbg_mem_pkg::OFS_CTRL, c);
    apb(1'b1, dbg_mem_pkg::OFS_CMD, m);
    run <= 1'b1;
    n = 0;
    do begin
      apb(1'b0, dbg_mem_pkg::OFS_STATUS, 32'h0000_0000);
      n++;
    end while (q[dbg_mem_pkg::STAT_DONE_BIT] !== 1'b1 && n < 500);
    run <= 1'b0;
    if (n >= 500) begin
      n_fail++;
      conclude;
    end
  endtask

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, run, slow, ihit, dhit, ivalid} = '0;
    {I_ICACHE_ENABLE_BIT, I_DCACHE_ENABLE_BIT, n_fail, comparisons} = '0;
    I_SYS_RST = 1'b1;
    repeat (12) @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    @(posedge I_SYS_CLK);
    apb(1'b0, dbg_mem_pkg::OFS_CTRL, 32'h0000_0000);
    chk32(q, 32'h0000_0000);
    apb(1'b0, dbg_mem_pkg::OFS_WR_DELAY, 32'h0000_0000);
    chk32(q, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk32({q[31:1], q[0] | ~err}, 32'h0000_0000);
    apb(1'b1, dbg_mem_pkg::OFS_STATUS, 32'h0000_0003);
    chk32({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, dbg_mem_pkg::OFS_WR_DELAY, 32'h00FF_FFFF);
    apb(1'b0, dbg_mem_pkg::OFS_WR_DELAY, 32'h0000_0000);
    chk32(q, {8'h00, dbg_mem_pkg::WR_DELAY_MAX});
    apb(1'b1, dbg_mem_pkg::OFS_WR_DELAY, 32'h0000_0000);
    apb(1'b1, dbg_mem_pkg::OFS_ADDR, 32'h0000_1000);
    apb(1'b1, dbg_mem_pkg::OFS_WDATA_LO, 32'h0103_0700);
    apb(1'b1, dbg_mem_pkg::OFS_WDATA_HI, 32'h0000_01FF);
    // Reads: {ctrl[3:0], ic_en, dc_en, ihit, dhit, ivalid}
    rc = '{9'h007, 9'h11F, 9'h01F, 9'h01D, 9'h01C, 9'h019, 9'h040};
    rx = '{PHYS, PHYS, DCV, ICV ^ dbg_mem_pkg::ICODE_KEY, ICV, PHYS,
           {32'h0000_0000, PHYS[31:0]}};
    for (i = 0; i < 7; i++) begin
      {I_ICACHE_ENABLE_BIT, I_DCACHE_ENABLE_BIT, ihit, dhit, ivalid} <= rc[i][4:0];
      run_op({28'h000_0000, rc[i][8:5]}, 32'h0000_0010);
      apb(1'b0, dbg_mem_pkg::OFS_RDATA_LO, 32'h0000_0000);
      chk32(q, rx[i][31:0]);
      apb(1'b0, dbg_mem_pkg::OFS_RDATA_HI, 32'h0000_0000);
      chk32(q, rx[i][63:32]);
    end
    // Writes: {ctrl[5:0], cmd[4:0], ic_en, dc_en, ihit, dhit}
    wc = '{15'h019F, 15'h039C, 15'h219F, 15'h499F, 15'h0993, 15'h011F, 15'h012F};
    wx = '{15'h000C, 15'h1520, 15'h0028, 15'h0060, 15'h0020, 15'h0038, 15'h0023};
    for (i = 0; i < 7; i++) begin
      {I_ICACHE_ENABLE_BIT, I_DCACHE_ENABLE_BIT, ihit, dhit} <= wc[i][3:0];
      slow <= (i == 2);
      run_op({26'h000_0000, wc[i][14:9]}, {27'h000_0000, wc[i][8:4]});
      chk32({17'h0_0000, last_wr.data_parity, last_wr.retry_mode, last_wr.wr_phys,
             last_wr.wr_icache, last_wr.wr_dcache, last_wr.mark_dirty, last_wr.inv_icache,
             last_wr.inv_dcache}, {17'h0_0000, wx[i]});
      chk32(last_wr.data[63:32], 32'h0000_01FF);
      chk32(last_wr.addr, 32'h0000_1000);
    end
    chk32({31'h0000_0000, gap < 2000}, 32'h0000_0001);
    // Narrow bus with parity: 8-byte request cut to 4 bytes
    run_op(32'h0000_0003, 32'h0000_0019);
    chk32({23'h00_0000, last_wr.data_parity, last_wr.size4}, 32'h0000_0015);
    chk32(last_wr.data[63:32], 32'h0000_0000);
    apb(1'b1, dbg_mem_pkg::OFS_WR_DELAY, 32'h0000_0002);
    run_op(32'h0000_0000, 32'h0000_0019);
    chk32({31'h0000_0000, gap >= 2000}, 32'h0000_0001);
    apb(1'b1, dbg_mem_pkg::OFS_CMD, 32'h0000_0019);
    run <= 1'b1;
    apb(1'b1, dbg_mem_pkg::OFS_CMD, 32'h0000_0019);
    chk32({31'h0000_0000, err}, 32'h0000_0001);
    repeat (600) @(posedge I_SYS_CLK);
    run <= 1'b0;
    conclude;
  end
endmodule // dbg_mem_policy_test
